// ==== pkg/trs_consts.svh ====
`ifndef TRS_CONSTS_SVH
`define TRS_CONSTS_SVH

// transmit pll multiplication factors
`define TRS_MULT_FULL 5'h0A
`define TRS_MULT_HALF 5'h14
`define TRS_MULT_RESET 5'h0A

// half-period measurement counter width and its saturation value
`define TRS_CNT_W 8
`define TRS_CNT_MAX 8'hFF

// reset values of the character register
`define TRS_DATA_RESET 8'h00
`define TRS_CTL_RESET 2'h0

`endif

// ==== pkg/trs_pkg.sv ====
// Purpose: types shared by the transmit clock and rate select block
// Assumes: constants live in trs_consts.svh
// Notes: three-level selects arrive already resolved to two bits
package trs_pkg;

  typedef enum logic [1:0] {
    TRS_SEL_LOW  = 2'h0,
    TRS_SEL_MID  = 2'h1,
    TRS_SEL_HIGH = 2'h2
  } trs_level_t;

  typedef struct packed {
    logic [1:0] ctl;
    logic [7:0] data;
  } trs_char_t;

  typedef struct packed {
    trs_level_t inSel;
    logic rateHigh;
    logic rxFromRef;
  } trs_cfg_t;

endpackage

// ==== core/trs_tx_clock_rate_select.sv ====
// Purpose: transmit input clock select, pll rate select, tx clock output
//          and receive parallel clock source for one channel
// Assumes: core_clk is much faster than the reference clock, which is
//          sampled as a pin; hostInputClock is the link clock domain
// Notes: the pll is modelled digitally by edge tracking of the reference
`include "trs_consts.svh"

// Notes on behaviour
// - select low: load on reference rising edge
// - select high/mid: capture on host clock
// - true and complement tx clock output
// - tx clock equals reference, doubled when high
// - no phase alignment to reference guaranteed
// - rate high: multiply reference by twenty
// - rate low: multiply reference by ten
// - rx clocks half-rate, follow reference
// - rx clocks full-rate, follow reference
// - half-rate reference: sample on both edges
module trs_tx_clock_rate_select
  import trs_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic hostInputClock,
  input wire logic referenceClock,
  input wire logic [1:0] inputClockSelect,
  input wire logic refclkRateSelect,
  input wire logic rxClockSourceSelect,
  input wire logic rxRecoveredClock,
  input wire logic [7:0] txData,
  input wire logic [1:0] txCharControl,
  output logic [9:0] txChar,
  output logic txCharValid,
  output logic txClockOut,
  output logic txClockOutN,
  output logic [4:0] pllMultiplier,
  output logic rxParallelClock,
  output logic rxParallelClockN,
  output logic rxParallelClockCopy,
  output logic rxHalfRate,
  output logic configInvalid,
  output logic configChanged
);

  // host clock domain: reset crossing and input register
  logic hostRst1_r, hostRst2_r;
  trs_char_t hostChar_r, hostChar_nxt;
  logic hostTgl_r, hostTgl_nxt;

  always_comb
  begin
    hostChar_nxt = hostChar_r;
    hostTgl_nxt = hostTgl_r;
    if (!hostRst2_r)
    begin
      hostChar_nxt = '{ctl: `TRS_CTL_RESET, data: `TRS_DATA_RESET};
      hostTgl_nxt = 1'b0;
    end
    else
    begin
      // captured every host edge; the core side decides whether to use it
      hostChar_nxt = '{ctl: txCharControl, data: txData};
      hostTgl_nxt = ~hostTgl_r;
    end
  end

  always_ff @(posedge hostInputClock)
  begin
    hostRst1_r <= reset_n;
    hostRst2_r <= hostRst1_r;
    hostChar_r <= hostChar_nxt;
    hostTgl_r <= hostTgl_nxt;
  end

  // core domain: pin synchronisers
  trs_cfg_t cfg1_r, cfg2_r, cfgSeen_r;
  logic ref1_r, ref2_r, refPrev_r;
  logic rec1_r, rec2_r;
  logic tgl1_r, tgl2_r, tglPrev_r;
  trs_char_t pin1_r, pin2_r;

  always_ff @(posedge core_clk)
  begin
    cfg1_r <= '{inSel: trs_level_t'(inputClockSelect),
                rateHigh: refclkRateSelect,
                rxFromRef: ~rxClockSourceSelect};
    cfg2_r <= cfg1_r;
    ref1_r <= referenceClock;
    ref2_r <= ref1_r;
    rec1_r <= rxRecoveredClock;
    rec2_r <= rec1_r;
    tgl1_r <= hostTgl_r;
    tgl2_r <= tgl1_r;
    pin1_r <= '{ctl: txCharControl, data: txData};
    pin2_r <= pin1_r;
  end

  // core domain: character register, clock synthesis, status
  logic refRise, refFall, refEdge, hostEvt, useRef;
  logic [`TRS_CNT_W-1:0] cnt_r, cnt_nxt, half_r, half_nxt;
  trs_char_t char_r, char_nxt;
  logic valid_r, valid_nxt;
  logic host_input_clock_r, host_input_clock_nxt;
  logic [4:0] mult_r, mult_nxt;
  logic rx_parallel_clock_r, rx_parallel_clock_nxt;
  logic rxHalf_r, rxHalf_nxt;
  logic bad_r, bad_nxt;
  logic chg_r, chg_nxt;
  logic armed_r, armed_nxt;
  logic refPrev_nxt, tglPrev_nxt;
  trs_cfg_t cfgSeen_nxt;

  assign refRise = ref2_r & ~refPrev_r;
  assign refFall = ~ref2_r & refPrev_r;
  assign refEdge = refRise | refFall;
  assign hostEvt = tgl2_r ^ tglPrev_r;
  assign useRef = (cfg2_r.inSel == TRS_SEL_LOW);

  always_comb
  begin
    refPrev_nxt = ref2_r;
    tglPrev_nxt = tgl2_r;
    cnt_nxt = cnt_r;
    half_nxt = half_r;
    char_nxt = char_r;
    valid_nxt = 1'b0;
    host_input_clock_nxt = host_input_clock_r;
    mult_nxt = mult_r;
    rx_parallel_clock_nxt = rx_parallel_clock_r;
    rxHalf_nxt = rxHalf_r;
    bad_nxt = bad_r;
    chg_nxt = chg_r;
    armed_nxt = armed_r;
    cfgSeen_nxt = cfgSeen_r;
    if (!reset_n)
    begin
      cnt_nxt = '0;
      half_nxt = '0;
      char_nxt = '{ctl: `TRS_CTL_RESET, data: `TRS_DATA_RESET};
      host_input_clock_nxt = 1'b0;
      mult_nxt = `TRS_MULT_RESET;
      rx_parallel_clock_nxt = 1'b0;
      rxHalf_nxt = 1'b0;
      bad_nxt = 1'b0;
      chg_nxt = 1'b0;
      armed_nxt = 1'b0;
      cfgSeen_nxt = '{inSel: TRS_SEL_LOW, rateHigh: 1'b0, rxFromRef: 1'b0};
    end
    else
    begin
      // half-period of the reference measured in core cycles
      if (refEdge)
      begin
        half_nxt = cnt_r;
        cnt_nxt = `TRS_CNT_W'(1);
      end
      else if (cnt_r != `TRS_CNT_MAX)
      begin
        cnt_nxt = cnt_r + `TRS_CNT_W'(1);
      end
      // every reference edge toggles: same frequency as the reference
      if (refEdge)
      begin
        host_input_clock_nxt = ~host_input_clock_r;
      end
      // rate high adds a mid-point toggle to double the frequency;
      // phase tracks the sampled reference, not the pin itself
      else if (cfg2_r.rateHigh && half_r > `TRS_CNT_W'(1) &&
               cnt_r == (half_r >> 1))
      begin
        host_input_clock_nxt = ~host_input_clock_r;
      end
      mult_nxt = cfg2_r.rateHigh ? `TRS_MULT_HALF
                                 : `TRS_MULT_FULL;
      // input register load
      if (useRef)
      begin
        if (refRise || (cfg2_r.rateHigh && refFall))
        begin
          char_nxt = pin2_r;
          valid_nxt = 1'b1;
        end
      end
      else if (hostEvt)
      begin
        char_nxt = hostChar_r;
        valid_nxt = 1'b1;
      end
      // receive parallel clocks follow the reference in both rates, or the recovered clock when rxClockSourceSelect is set
      if (cfg2_r.rxFromRef)
      begin
        rx_parallel_clock_nxt = ref2_r;
        rxHalf_nxt = cfg2_r.rateHigh;
      end
      else
      begin
        rx_parallel_clock_nxt = rec2_r;
        rxHalf_nxt = 1'b0;
      end
      // flagged only; the device keeps running in the unsupported mode
      bad_nxt = cfg2_r.rateHigh && !useRef;
      // setting is recorded every cycle; any change from one cycle to the next is sticky
      armed_nxt = 1'b1;
      cfgSeen_nxt = cfg2_r;
      if (armed_r && cfg2_r != cfgSeen_r)
      begin
        chg_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    refPrev_r <= refPrev_nxt;
    tglPrev_r <= tglPrev_nxt;
    cnt_r <= cnt_nxt;
    half_r <= half_nxt;
    char_r <= char_nxt;
    valid_r <= valid_nxt;
    host_input_clock_r <= host_input_clock_nxt;
    mult_r <= mult_nxt;
    rx_parallel_clock_r <= rx_parallel_clock_nxt;
    rxHalf_r <= rxHalf_nxt;
    bad_r <= bad_nxt;
    chg_r <= chg_nxt;
    armed_r <= armed_nxt;
    cfgSeen_r <= cfgSeen_nxt;
  end

  // outputs straight from flip-flops
  logic txClkN_r, rxClkN_r, rxCopy_r;

  always_ff @(posedge core_clk)
  begin
    txClkN_r <= ~host_input_clock_nxt;
    rxClkN_r <= ~rx_parallel_clock_nxt;
    rxCopy_r <= rx_parallel_clock_nxt;
  end

  assign txChar = char_r;
  assign txCharValid = valid_r;
  assign txClockOut = host_input_clock_r;
  assign txClockOutN = txClkN_r;
  assign pllMultiplier = mult_r;
  assign rxParallelClock = rx_parallel_clock_r;
  assign rxParallelClockN = rxClkN_r;
  assign rxParallelClockCopy = rxCopy_r;
  assign rxHalfRate = rxHalf_r;
  assign configInvalid = bad_r;
  assign configChanged = chg_r;

endmodule

// ==== testbench/trs_host_model.sv ====
// Purpose: host logic presenting characters on the transmit pins
// Assumes: loadClk is the load clock, shifted clear of the capture edges
// Notes: pins move on the falling edge, or on both edges when dual is set
module trs_host_model
  import trs_pkg::*;
(
  input wire logic loadClk,
  input wire logic dual,
  output trs_char_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins = '0;
  // counting pattern, so a stale load shows as a wrong value
  always @(posedge loadClk or negedge loadClk)
    if (dual || !loadClk)
      pins <= trs_char_t'(pins + 10'h001);
endmodule

// ==== testbench/trs_checker.sv ====
// Purpose: port checks for the tx clock and rate select block
// Assumes: selects change only while reset is held, bar a MID/HIGH swap
// Notes: windows allow for the pin synchroniser lag
module trs_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic hostInputClock,
  input wire logic referenceClock,
  input wire logic [1:0] inputClockSelect,
  input wire logic refclkRateSelect,
  input wire logic rxClockSourceSelect,
  input wire logic txCharValid,
  input wire logic txClockOut,
  input wire logic txClockOutN,
  input wire logic [4:0] pllMultiplier,
  input wire logic rxParallelClock,
  input wire logic rxHalfRate,
  input wire logic configInvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  // host side leaves reset two host edges late, so early edges load nothing
  logic hostPrev_r, hostPrev_nxt;
  logic [1:0] hostSeen_r, hostSeen_nxt;
  always_comb
  begin
    hostPrev_nxt = hostInputClock;
    hostSeen_nxt = hostSeen_r;
    if (!reset_n)
      hostSeen_nxt = 2'h0;
    else if (hostInputClock && !hostPrev_r && !hostSeen_r[1])
      hostSeen_nxt = hostSeen_r + 2'h1;
  end
  always_ff @(posedge core_clk)
  begin
    hostPrev_r <= hostPrev_nxt;
    hostSeen_r <= hostSeen_nxt;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_tx_pair: assert property (txClockOutN != txClockOut)
    else $error("tx pair");
  a_ref_load: assert property (inputClockSelect == 2'h0 &&
    $rose(referenceClock) |-> ##[1:5] txCharValid) else $error("ref load");
  a_host_load: assert property (hostSeen_r[1] &&
    inputClockSelect != 2'h0 && $rose(hostInputClock) |-> ##[1:6] txCharValid)
    else $error("host load");
  a_tx_follow: assert property ($rose(referenceClock)
    |-> ##[1:5] $changed(txClockOut)) else $error("tx clock");
  a_mult_rate: assert property ($stable(refclkRateSelect)[*4]
    |-> pllMultiplier == (refclkRateSelect ? 5'h14 : 5'h0A))
    else $error("mult");
  a_rx_follow: assert property (!rxClockSourceSelect &&
    $rose(referenceClock) |-> ##[1:5] $rose(rxParallelClock))
    else $error("rx clock");
  a_rx_half: assert property ($stable(refclkRateSelect)[*4]
    |-> rxHalfRate == (refclkRateSelect && !rxClockSourceSelect))
    else $error("rx half");
  a_bad_mode: assert property ($stable(inputClockSelect)[*4]
    |-> configInvalid == (refclkRateSelect && inputClockSelect != 2'h0))
    else $error("bad mode");
endmodule

bind trs_tx_clock_rate_select trs_checker chk (.*);

// ==== testbench/tb_top.sv ====
// Purpose: bench for the tx clock and rate select block
// Assumes: selects change only with reset held, bar one MID/HIGH swap
// Notes: counts run over a fixed window, so edge counts get slack
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstN, hClk, rClk, rate, rxSel, win, vld, txc, rxc, rxH, bad;
  logic txN, rxN, rxCp, chg, txcQ, rxcQ;
  logic rClkQ = 1'b0;
  logic [1:0] sel;
  logic [9:0] ch;
  logic [4:0] mul;
  trs_pkg::trs_char_t pins;
  int n_fail, compares, nVal, nTx, nRx;
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always #100 rClk = ~rClk;
  initial #33 forever #80 hClk = ~hClk;
  trs_tx_clock_rate_select uut (.core_clk(clk), .reset_n(rstN),
    .hostInputClock(hClk), .referenceClock(rClk), .inputClockSelect(sel),
    .refclkRateSelect(rate), .rxClockSourceSelect(rxSel),
    .rxRecoveredClock(hClk), .txData(pins.data), .txCharControl(pins.ctl),
    .txChar(ch), .txCharValid(vld), .txClockOut(txc), .txClockOutN(txN),
    .pllMultiplier(mul), .rxParallelClock(rxc), .rxParallelClockN(rxN),
    .rxParallelClockCopy(rxCp), .rxHalfRate(rxH), .configInvalid(bad),
    .configChanged(chg));
  // pins move 50 ns after a reference edge, clear of both capture edges
  always @(rClk) rClkQ <= #50 rClk;
  trs_host_model host (.loadClk(sel == 2'h0 ? rClkQ : hClk),
    .dual(rate && sel == 2'h0), .pins(pins));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %0h %0h", $time, seen, exp);
    end
  endtask
  // settled values are read mid-cycle, clear of the launching edge
  always @(negedge clk)
  begin
    if (win)
    begin
      nVal += vld;
      nTx += (txc != txcQ);
      nRx += (rxc != rxcQ);
      if (vld === 1'b1)
        check(ch, pins);
      check({txN, rxN, rxCp}, {~txc, ~rxc, rxc});
    end
    txcQ = txc;
    rxcQ = rxc;
  end
  task automatic apply(input logic [1:0] s, input logic r, input logic x);
    {rstN, sel, rate, rxSel} = {1'b0, s, r, x};
    repeat (70) @(posedge clk);
    #1 rstN = 1;
    repeat (60) @(posedge clk);
    #1;
  endtask
  task automatic measure(input int v, input int t, input int r);
    {nVal, nTx, nRx} = '0;
    win = 1;
    repeat (400) @(posedge clk);
    #1 win = 0;
    check(nVal >= v - 1 && nVal <= v + 1, 1);
    check(nTx >= t - 2 && nTx <= t + 2, 1);
    check(nRx >= r - 2 && nRx <= r + 2, 1);
  endtask
  task automatic sc_ref_full;
    apply(2'h0, 0, 0);
    measure(20, 40, 40);
    check(mul, 5'h0A);
  endtask
  task automatic sc_ref_half;
    apply(2'h0, 1, 0);
    measure(40, 80, 40);
    check(mul, 5'h14);
    check(rxH, 1);
  endtask
  task automatic sc_host(input logic [1:0] s);
    apply(s, 0, 1);
    measure(25, 40, 50);
    check(bad, 0);
  endtask
  task automatic sc_bad_mode;
    apply(2'h1, 1, 0);
    check(bad, 1);
    check(chg, 0);
    sel = 2'h2;
    repeat (10) @(posedge clk);
    #1;
    check(chg, 1);
    check(bad, 1);
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    {rstN, sel, rate, rxSel, win, rClk, hClk} = '0;
    repeat (20) @(posedge clk);
    #1;
    sc_ref_full;
    sc_ref_half;
    sc_host(2'h1);
    sc_host(2'h2);
    sc_bad_mode;
    tally_and_finish;
  end
endmodule
